// *** hw/lac_pkg.sv ***
package lac_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_START    = 12'h004;
  localparam logic [11:0] OFS_STATUS   = 12'h008;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h00c;
  localparam logic [11:0] OFS_IRQ_CLR  = 12'h010;
  localparam logic [11:0] OFS_IRQ_EN   = 12'h014;
  localparam logic [11:0] OFS_RET      = 12'h018;

  // Control register bits
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_ABORT_BIT = 1;

  // Interrupt status bits
  localparam int IRQ_END_BIT  = 0;
  localparam int IRQ_TXB_BIT  = 1;
  localparam int IRQ_RXB_BIT  = 2;
  localparam int IRQ_ERR_BIT  = 3;

  // Reset values
  localparam logic [31:0] START_RST  = 32'h0000_0000;
  localparam logic [3:0]  IRQ_EN_RST = 4'h0;

  // Command word 0 layout
  localparam int OP_LSB    = 24;
  localparam int CHAIN_BIT = 23;
  localparam int TMR_LSB   = 20;
  localparam int CNT_LSB   = 0;

  // Operation codes
  localparam logic [7:0] OP_CMP_EQ  = 8'h01;
  localparam logic [7:0] OP_CMP_NE  = 8'h02;
  localparam logic [7:0] OP_CALL    = 8'h03;
  localparam logic [7:0] OP_RETURN  = 8'h04;
  localparam logic [7:0] OP_TX_BRK  = 8'h05;
  localparam logic [7:0] OP_RX_BRK  = 8'h06;

  // Highest supported timer encoding
  localparam logic [2:0] TMR_MAX = 3'h5;

  // Completion codes
  localparam logic [7:0] END_NONE    = 8'h00;
  localparam logic [7:0] END_OK      = 8'h01;
  localparam logic [7:0] END_BRK_RX  = 8'h10;
  localparam logic [7:0] END_ABORT   = 8'h80;
  localparam logic [7:0] END_INV_CMD = 8'hc2;
  localparam logic [7:0] END_INV_TMR = 8'hc6;

  // Timing
  localparam longint CLK_HZ      = 100_000_000;
  localparam longint BRK_TX_MS   = 200;
  localparam longint BRK_RX_MS   = 150;
  localparam int     BRK_TX_CYC  = int'((BRK_TX_MS * CLK_HZ) / 1000);
  localparam int     BRK_RX_CYC  = int'((BRK_RX_MS * CLK_HZ) / 1000);
  localparam int     BRK_CNT_W   = 25;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } lac_mem_req_t;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_FETCH  = 4'b0001,
    ST_DECODE = 4'b0011,
    ST_RDA    = 4'b0010,
    ST_RDB    = 4'b0110,
    ST_EVAL   = 4'b0111,
    ST_TXB    = 4'b0101,
    ST_RXB    = 4'b0100
  } lac_st_t;

  typedef struct packed {
    lac_st_t          st;
    logic [31:0]      pc;
    logic [31:0]      ret;
    logic [31:0]      start;
    logic [3:0][31:0] w;
    logic [1:0]       widx;
    logic [4:0]       idx;
    logic             eq;
    logic [7:0]       byte_a;
    logic [7:0]       code;
    logic             busy;
    logic [3:0]       irq_st;
    logic [3:0]       irq_en;
    logic             irq;
    logic             rdy;
    logic             slverr;
    logic [31:0]      rdata;
    lac_mem_req_t     mem;
    logic             tx_go;
    logic             rx_arm;
    logic             stop;
  } lac_state_t;

  typedef struct packed {
    logic                 rx_m;
    logic                 rx_s;
    logic                 txd;
    logic                 tx_busy;
    logic [BRK_CNT_W-1:0] tx_cnt;
    logic [BRK_CNT_W-1:0] rx_cnt;
    logic                 tx_done;
    logic                 rx_brk;
  } lac_brk_state_t;

endpackage

// *** hw/lac_break_unit.sv ***
`timescale 1ns/100ps
module lac_break_unit
  import lac_pkg::*;
#(
  parameter int TX_CYC = BRK_TX_CYC,
  parameter int RX_CYC = BRK_RX_CYC
)(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // Control
  input  wire logic tx_go_i,
  input  wire logic rx_arm_i,
  input  wire logic stop_i,
  // Line
  input  wire logic line_rxd_i,
  output logic      line_txd_o,
  // Events
  output logic      tx_done_o,
  output logic      rx_brk_o
);

  lac_brk_state_t s, n;

  always_comb
  begin
    n         = s;
    n.rx_m    = line_rxd_i;
    n.rx_s    = s.rx_m;
    n.tx_done = 1'b0;
    n.rx_brk  = 1'b0;
    if (stop_i)
    begin
      n.tx_busy = 1'b0;
      n.txd     = 1'b1;
    end
    else if (s.tx_busy)
    begin
      if (s.tx_cnt == BRK_CNT_W'(1))
      begin
        n.tx_busy = 1'b0;
        n.txd     = 1'b1;
        n.tx_done = 1'b1;
      end
      else
        n.tx_cnt = s.tx_cnt - BRK_CNT_W'(1);
    end
    else if (tx_go_i)
    begin
      n.tx_busy = 1'b1;
      n.txd     = 1'b0;
      n.tx_cnt  = BRK_CNT_W'(TX_CYC);
    end
    if (rx_arm_i && !stop_i && !s.rx_s)
    begin
      if (s.rx_cnt == BRK_CNT_W'(RX_CYC - 1))
      begin
        n.rx_brk = 1'b1;
        n.rx_cnt = '0;
      end
      else
        n.rx_cnt = s.rx_cnt + BRK_CNT_W'(1);
    end
    else
      n.rx_cnt = '0;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      s      <= '0;
      s.rx_m <= 1'b1;
      s.rx_s <= 1'b1;
      s.txd  <= 1'b1;
    end
    else
      s <= n;
  end

  assign line_txd_o = s.txd;
  assign tx_done_o  = s.tx_done;
  assign rx_brk_o   = s.rx_brk;

endmodule // lac_break_unit

// *** hw/lac_cmd_flow.sv ***
`timescale 1ns/100ps
module lac_cmd_flow
  import lac_pkg::*;
#(
  parameter int TX_CYC = BRK_TX_CYC,
  parameter int RX_CYC = BRK_RX_CYC
)(
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // APB slave
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [11:0]  paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic              pready_o,
  output logic      [31:0]  prdata_o,
  output logic              pslverr_o,
  // Storage read port
  output lac_mem_req_t      mem_o,
  input  wire logic         mem_ack_i,
  input  wire logic [31:0]  mem_rdata_i,
  // Line
  output logic              line_txd_o,
  input  wire logic         line_rxd_i,
  // Interrupt
  output logic              irq_o
);

  lac_state_t s, n;
  logic       tx_done_w;
  logic       rx_brk_w;

  function automatic logic [2:0] cmd_len(input logic [7:0] op);
    case (op)
      OP_CMP_EQ, OP_CMP_NE: cmd_len = 3'd4;
      OP_CALL:              cmd_len = 3'd2;
      default:              cmd_len = 3'd1;
    endcase
  endfunction

  function automatic logic [7:0] byte_sel(input logic [31:0] word, input logic [1:0] lane);
    byte_sel = word[8*lane +: 8];
  endfunction

  lac_break_unit #(
    .TX_CYC (TX_CYC),
    .RX_CYC (RX_CYC)
  ) u_brk (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .tx_go_i    (s.tx_go),
    .rx_arm_i   (s.rx_arm),
    .stop_i     (s.stop),
    .line_rxd_i (line_rxd_i),
    .line_txd_o (line_txd_o),
    .tx_done_o  (tx_done_w),
    .rx_brk_o   (rx_brk_w)
  );

  always_comb
  begin
    logic        acc;
    logic        wr;
    logic        fin;
    logic        adv;
    logic        take;
    logic [7:0]  fin_code;
    logic [3:0]  ev;
    logic [3:0]  clr;
    logic [7:0]  op;
    logic [31:0] next_pc;
    logic [31:0] baddr;
    acc      = psel_i && penable_i && s.rdy;
    wr       = acc && pwrite_i;
    fin      = 1'b0;
    adv      = 1'b0;
    take     = 1'b0;
    fin_code = END_NONE;
    ev       = 4'h0;
    clr      = 4'h0;
    op       = s.w[0][OP_LSB +: 8];
    next_pc  = s.pc + 32'({cmd_len(op), 2'b00});
    baddr    = 32'h0000_0000;
    n        = s;
    n.tx_go  = 1'b0;
    n.stop   = 1'b0;

    // Register writes take effect on the completing edge
    if (wr)
    begin
      case (paddr_i)
        OFS_START:   n.start  = pwdata_i;
        OFS_IRQ_EN:  n.irq_en = pwdata_i[3:0];
        OFS_IRQ_CLR: clr      = pwdata_i[3:0];
        default:     ;
      endcase
    end

    case (s.st)
      ST_IDLE:
      begin
        if (wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_START_BIT])
        begin
          n.st   = ST_FETCH;
          n.pc   = s.start;
          n.widx = 2'd0;
          n.busy = 1'b1;
          n.code = END_NONE;
        end
      end
      ST_FETCH:
      begin
        if (!s.mem.req)
        begin
          n.mem.req  = 1'b1;
          n.mem.addr = s.pc + 32'({s.widx, 2'b00});
        end
        else if (mem_ack_i)
        begin
          n.mem.req    = 1'b0;
          n.w[s.widx]  = mem_rdata_i;
          op           = (s.widx == 2'd0) ? mem_rdata_i[OP_LSB +: 8] : s.w[0][OP_LSB +: 8];
          if ({1'b0, s.widx} + 3'd1 < cmd_len(op))
            n.widx = s.widx + 2'd1;
          else
            n.st = ST_DECODE;
        end
      end
      ST_DECODE:
      begin
        n.widx = 2'd0;
        if (op < OP_CMP_EQ || op > OP_RX_BRK)
        begin
          fin      = 1'b1;
          fin_code = END_INV_CMD;
        end
        else if (s.w[0][TMR_LSB +: 3] > TMR_MAX)
        begin
          fin      = 1'b1;
          fin_code = END_INV_TMR;
        end
        else
        begin
          case (op)
            OP_CMP_EQ, OP_CMP_NE:
            begin
              n.idx = 5'd0;
              n.eq  = 1'b1;
              n.st  = (s.w[0][CNT_LSB +: 5] == 5'd0) ? ST_EVAL : ST_RDA;
            end
            OP_CALL:
            begin
              n.ret = next_pc;
              n.pc  = s.w[1];
              n.st  = ST_FETCH;
            end
            OP_RETURN:
            begin
              n.pc = s.ret;
              n.st = ST_FETCH;
            end
            OP_TX_BRK:
            begin
              n.tx_go = 1'b1;
              n.st    = ST_TXB;
            end
            default:
            begin
              n.rx_arm = 1'b1;
              n.st     = ST_RXB;
            end
          endcase
        end
      end
      ST_RDA, ST_RDB:
      begin
        baddr = (s.st == ST_RDA) ? s.w[1] : s.w[2];
        baddr = baddr + 32'(s.idx);
        if (!s.mem.req)
        begin
          n.mem.req  = 1'b1;
          n.mem.addr = {baddr[31:2], 2'b00};
        end
        else if (mem_ack_i)
        begin
          n.mem.req = 1'b0;
          if (s.st == ST_RDA)
          begin
            n.byte_a = byte_sel(mem_rdata_i, baddr[1:0]);
            n.st     = ST_RDB;
          end
          else
          begin
            if (byte_sel(mem_rdata_i, baddr[1:0]) != s.byte_a)
              n.eq = 1'b0;
            n.idx = s.idx + 5'd1;
            n.st  = (s.idx + 5'd1 == s.w[0][CNT_LSB +: 5]) ? ST_EVAL : ST_RDA;
          end
        end
      end
      ST_EVAL:
      begin
        take = (op == OP_CMP_EQ) ? s.eq : !s.eq;
        if (take)
        begin
          n.pc = s.w[3];
          n.st = ST_FETCH;
        end
        else
          adv = 1'b1;
      end
      ST_TXB:
      begin
        if (tx_done_w)
        begin
          ev[IRQ_TXB_BIT] = 1'b1;
          n.code          = END_OK;
          adv             = 1'b1;
        end
      end
      ST_RXB:
      begin
        if (rx_brk_w)
        begin
          ev[IRQ_RXB_BIT] = 1'b1;
          n.rx_arm        = 1'b0;
          n.code          = END_BRK_RX;
          adv             = 1'b1;
        end
      end
      default:
      begin
        fin      = 1'b1;
        fin_code = END_INV_CMD;
      end
    endcase

    if (adv)
    begin
      if (s.w[0][CHAIN_BIT])
      begin
        n.pc = next_pc;
        n.st = ST_FETCH;
      end
      else
      begin
        fin      = 1'b1;
        fin_code = (n.code == END_NONE) ? END_OK : n.code;
      end
    end

    if (wr && paddr_i == OFS_CTRL && pwdata_i[CTRL_ABORT_BIT] && s.busy)
    begin
      fin      = 1'b1;
      fin_code = END_ABORT;
    end

    if (fin)
    begin
      n.st       = ST_IDLE;
      n.busy     = 1'b0;
      n.code     = fin_code;
      n.mem.req  = 1'b0;
      n.tx_go    = 1'b0;
      n.rx_arm   = 1'b0;
      n.stop     = 1'b1;
      ev[IRQ_END_BIT] = 1'b1;
      if (fin_code == END_INV_CMD || fin_code == END_INV_TMR)
        ev[IRQ_ERR_BIT] = 1'b1;
    end

    // Set wins over clear
    n.irq_st = (s.irq_st & ~clr) | ev;
    n.irq    = |(n.irq_st & n.irq_en);

    // APB answer one cycle into the access phase
    n.rdy    = psel_i && penable_i && !s.rdy;
    n.slverr = 1'b0;
    n.rdata  = 32'h0000_0000;
    if (psel_i && penable_i && !s.rdy)
    begin
      case (paddr_i)
        OFS_CTRL, OFS_IRQ_CLR: n.rdata = 32'h0000_0000;
        OFS_START:    n.rdata = s.start;
        OFS_STATUS:   n.rdata = {16'h0000, s.code, 7'h00, s.busy};
        OFS_IRQ_STAT: n.rdata = {28'h0000000, s.irq_st};
        OFS_IRQ_EN:   n.rdata = {28'h0000000, s.irq_en};
        OFS_RET:      n.rdata = s.ret;
        default:      n.slverr = 1'b1;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rstn_i)
    begin
      s        <= '0;
      s.st     <= ST_IDLE;
      s.start  <= START_RST;
      s.irq_en <= IRQ_EN_RST;
    end
    else
      s <= n;
  end

  assign pready_o  = s.rdy;
  assign prdata_o  = s.rdata;
  assign pslverr_o = s.slverr;
  assign mem_o     = s.mem;
  assign irq_o     = s.irq;

endmodule // lac_cmd_flow

// *** dv/lac_cmd_flow_assertions.sv ***
`timescale 1ns/100ps
module lac_cmd_flow_assertions
  import lac_pkg::*;
#(
  parameter int TX_CYC = BRK_TX_CYC
)(
  // Clock and reset
  input wire logic         core_clk_i,
  input wire logic         rstn_i,
  // APB
  input wire logic         psel_i,
  input wire logic         penable_i,
  input wire logic         pwrite_i,
  input wire logic [11:0]  paddr_i,
  input wire logic [31:0]  pwdata_i,
  input wire logic         pready_o,
  input wire logic [31:0]  prdata_o,
  input wire logic         pslverr_o,
  // Storage and line
  input wire lac_mem_req_t mem_o,
  input wire logic         mem_ack_i,
  input wire logic         line_txd_o
);
  logic [31:0] lo_q;
  logic        abort_w;

  // Abort write completing at this edge: storage request may drop without ack
  assign abort_w = psel_i && penable_i && pready_o && pwrite_i && paddr_i == OFS_CTRL && pwdata_i[CTRL_ABORT_BIT];

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rstn_i);

  // Length of the current space run on the line
  always_ff @(posedge core_clk_i)
    if (!rstn_i || line_txd_o)
      lo_q <= 32'h0;
    else
      lo_q <= lo_q + 32'h1;

  sequence s_wait;
    !pready_o ##1 pready_o;
  endsequence

  property p_wait;
    psel_i && $rose(penable_i) |-> s_wait;
  endproperty
  property p_one;
    pready_o |=> !pready_o;
  endproperty
  property p_err;
    pslverr_o |-> pready_o && psel_i && penable_i;
  endproperty
  property p_zero;
    !pready_o |-> prdata_o == 32'h0;
  endproperty
  property p_hold;
    mem_o.req && !mem_ack_i && !abort_w |=> mem_o.req && $stable(mem_o.addr);
  endproperty
  property p_abort;
    abort_w && mem_o.req |=> !mem_o.req;
  endproperty
  property p_drop;
    mem_o.req && mem_ack_i |=> !mem_o.req;
  endproperty
  property p_align;
    mem_o.req |-> mem_o.addr[1:0] == 2'h0;
  endproperty
  property p_tx;
    $rose(line_txd_o) |-> lo_q == TX_CYC;
  endproperty

  a_wait: assert property (p_wait) else $error("apb wait state wrong");
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  a_err: assert property (p_err) else $error("pslverr outside access");
  a_zero: assert property (p_zero) else $error("prdata not zero when idle");
  a_hold: assert property (p_hold) else $error("storage request not held");
  a_drop: assert property (p_drop) else $error("storage request not dropped");
  a_abort: assert property (p_abort) else $error("storage request kept after abort");
  a_align: assert property (p_align) else $error("storage address unaligned");
  a_tx: assert property (p_tx) else $error("space length wrong");
endmodule // lac_cmd_flow_assertions

bind lac_cmd_flow lac_cmd_flow_assertions #(.TX_CYC(TX_CYC)) u_lac_cmd_flow_assertions (
  .core_clk_i (core_clk_i),
  .rstn_i     (rstn_i),
  .psel_i     (psel_i),
  .penable_i  (penable_i),
  .pwrite_i   (pwrite_i),
  .paddr_i    (paddr_i),
  .pwdata_i   (pwdata_i),
  .pready_o   (pready_o),
  .prdata_o   (prdata_o),
  .pslverr_o  (pslverr_o),
  .mem_o      (mem_o),
  .mem_ack_i  (mem_ack_i),
  .line_txd_o (line_txd_o)
);

// *** dv/lac_mem_model.sv ***
`timescale 1ns/100ps
module lac_mem_model
  import lac_pkg::*;
(
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rstn_i,
  // Storage port
  input  wire lac_mem_req_t mem_i,
  output logic              mem_ack_o,
  output logic [31:0]       mem_rdata_o
);
  logic [31:0] mem [0:255];
  int          lat = 0;
  int          cnt = 0;

  // Data lines flip every cycle outside an answer
  always @(posedge core_clk_i)
  begin
    mem_ack_o <= 1'b0;
    mem_rdata_o <= ~mem_rdata_o;
    if (!rstn_i)
    begin
      cnt <= 0;
      mem_rdata_o <= 32'h5a5a_5a5a;
    end
    else if (mem_i.req && !mem_ack_o)
    begin
      if (cnt >= lat)
      begin
        mem_ack_o <= 1'b1;
        mem_rdata_o <= mem[mem_i.addr[9:2]];
        cnt <= 0;
      end
      else
        cnt <= cnt + 1;
    end
  end
endmodule // lac_mem_model

// *** dv/testbench.sv ***
`timescale 1ns/100ps
module testbench
  import lac_pkg::*;
;
  localparam int TXC = 20;
  logic         clk = 1'b0;
  logic         rstn = 1'b0;
  logic         psel = 1'b0;
  logic         pen = 1'b0;
  logic         pwr = 1'b0;
  logic [11:0]  paddr = 12'h0;
  logic [31:0]  pwdata = 32'h0;
  logic         rxd = 1'b1;
  logic         pready, pslverr, ack, txd, irq, e, jmp;
  logic [31:0]  prdata, rdata, st, irs, r;
  lac_mem_req_t mem;
  int           n_errors = 0;
  int           n_tests = 0;
  int           lo = 0;
  int           lo_last = 0;

  initial forever #5 clk = ~clk;

  lac_cmd_flow #(.TX_CYC(TXC), .RX_CYC(15)) u_lac_cmd_flow (
    .core_clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready), .prdata_o(prdata),
    .pslverr_o(pslverr), .mem_o(mem), .mem_ack_i(ack), .mem_rdata_i(rdata),
    .line_txd_o(txd), .line_rxd_i(rxd), .irq_o(irq));
  lac_mem_model u_lac_mem_model (
    .core_clk_i(clk), .rstn_i(rstn), .mem_i(mem), .mem_ack_o(ack), .mem_rdata_o(rdata));

  always @(posedge clk)
    if (txd === 1'b0)
      lo <= lo + 1;
    else if (lo != 0)
    begin
      lo_last <= lo;
      lo <= 0;
    end

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, x, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk);
    while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic mw(input int a, input logic [31:0] v);
    u_lac_mem_model.mem[a>>2] = v;
  endtask

  task automatic sb(input int a, input logic [7:0] v);
    u_lac_mem_model.mem[a>>2][8*(a%4)+:8] = v;
  endtask

  task automatic go(input logic [31:0] pc);
    apb(1'b1, OFS_IRQ_CLR, 32'hf);
    apb(1'b1, OFS_START, pc);
    apb(1'b1, OFS_CTRL, 32'h1);
  endtask

  task automatic fin();
    do apb(1'b0, OFS_STATUS, 32'h0);
    while (r[0] !== 1'b0);
    st = r;
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    irs = r;
  endtask

  initial
  begin
    #400000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    apb(1'b0, OFS_START, 32'h0);
    chk("start", r, START_RST);
    apb(1'b0, OFS_IRQ_EN, 32'h0);
    chk("irq_en", r, 32'(IRQ_EN_RST));
    apb(1'b0, 12'hffc, 32'h0);
    chk("unmapped", {r[30:0], e}, 32'h1);
    $display("test registers done");
    for (int k = 0; k < 31; k++)
    begin
      sb(12'h101 + k, k[7:0]);
      sb(12'h182 + k, k[7:0]);
    end
    mw(12'h004, 32'h101);
    mw(12'h008, 32'h182);
    mw(12'h00c, 32'h48);
    mw(12'h010, 32'hff00_0000);
    mw(12'h040, {OP_CALL, 24'h0});
    mw(12'h044, 32'h70);
    mw(12'h048, {OP_TX_BRK, 24'h0});
    mw(12'h070, {OP_RETURN, 24'h0});
    for (int i = 0; i < 8; i++)
    begin
      jmp = i[2] ? !i[0] : i[0];
      u_lac_mem_model.lat = i % 3;
      sb(12'h1a0, i[0] ? 8'h1e : 8'hff);
      mw(12'h000, {i[2] ? OP_CMP_NE : OP_CMP_EQ, i[1], 23'h1f});
      go(32'h0);
      fin();
      chk("cmp_code", st[15:8], jmp || !i[1] ? END_OK : END_INV_CMD);
      chk("cmp_irq", irs & 32'ha, jmp ? 32'h2 : (i[1] ? 32'h8 : 32'h0));
    end
    chk("irq_masked", irq, 1'b0);
    $display("test compare done");
    go(32'h40);
    fin();
    chk("call_code", st[15:8], END_OK);
    chk("call_irq", irs & 32'h2, 32'h2);
    apb(1'b0, OFS_RET, 32'h0);
    chk("ret", r, 32'h48);
    $display("test call done");
    for (int t = 5; t < 8; t++)
    begin
      mw(12'h050, {OP_TX_BRK, 1'b0, t[2:0], 20'h0});
      go(32'h50);
      fin();
      chk("timer", st[15:8], t == 5 ? END_OK : END_INV_TMR);
    end
    chk("tx_len", lo_last, TXC);
    $display("test timer done");
    mw(12'h054, {OP_RX_BRK, 24'h0});
    apb(1'b1, OFS_IRQ_EN, 32'h4);
    go(32'h54);
    rxd <= 1'b0;
    repeat (12) @(posedge clk);
    rxd <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("rx_short", r[0], 1'b1);
    rxd <= 1'b0;
    repeat (25) @(posedge clk);
    rxd <= 1'b1;
    fin();
    chk("rx_code", st[15:8], END_BRK_RX);
    chk("rx_irq", irs & 32'h4, 32'h4);
    chk("irq_on", irq, 1'b1);
    apb(1'b1, OFS_IRQ_CLR, 32'h4);
    apb(1'b0, OFS_IRQ_EN, 32'h0);
    chk("irq_en_rb", r, 32'h4);
    chk("irq_off", irq, 1'b0);
    $display("test receive break done");
    // Abort while a slow command fetch is outstanding
    u_lac_mem_model.lat = 50;
    go(32'h54);
    apb(1'b1, OFS_CTRL, 32'h2);
    fin();
    chk("abort_code", st[15:8], END_ABORT);
    chk("abort_irq", irs & 32'h9, 32'h1);
    $display("test abort done");
    end_sim();
  end
endmodule // testbench
